// ### verilog/aax_core.sv
`timescale 1ns/1ps
`include "aax_regs.svh"
module aax_core (
    input wire logic SYS_CLK_IN,
    input wire logic NRST_IN,
    input wire logic EXEC_IN,
    input wire logic [3:0] OP_IN,
    input wire logic DEST_IN,
    input wire logic [6:0] FILE_ADDR_IN,
    input wire logic [7:0] FILE_DATA_IN,
    input wire logic [7:0] LITERAL_IN,
    input wire logic WAKE_IN,
    output logic [7:0] ACC_OUT,
    output logic CARRY_OUT,
    output logic DIGIT_CARRY_FLAG_OUT,
    output logic ZERO_OUT,
    output logic TIMEOUT_FLAG_N_OUT,
    output logic POWERDOWN_FLAG_N_OUT,
    output logic [7:0] WATCHDOG_COUNTER_OUT,
    output logic [7:0] PRESCALER_OUT,
    output logic FILE_WE_OUT,
    output logic [6:0] FILE_WADDR_OUT,
    output logic [7:0] FILE_WDATA_OUT,
    output logic OSC_RUN_OUT,
    output logic SLEEPING_OUT
);
    aax_alu_if alu_bus (); // Link to the arithmetic unit.
    aax_pkg::aax_pwr_e pwr; // Power state.
    aax_pkg::aax_pwr_e next_pwr; // Next power state.
    logic wake_s1; // First wake synchroniser stage.
    logic wake_s2; // Second wake synchroniser stage.
    logic go; // An instruction executes this cycle.
    logic is_file_op; // Operation uses the file register as operand.
    logic upd_z; // Operation updates the zero flag.
    logic upd_cdc; // Operation updates carry and digit carry.

    // Operand selection: file forms use the file value, every other code the literal.
    assign is_file_op = (OP_IN == `AAX_OP_ROTR) || (OP_IN == `AAX_OP_SUBF) ||
                        (OP_IN == `AAX_OP_XORF) || (OP_IN == `AAX_OP_SWAP);
    assign alu_bus.op = OP_IN;
    assign alu_bus.acc = ACC_OUT;
    assign alu_bus.opnd = is_file_op ? FILE_DATA_IN : LITERAL_IN;
    assign alu_bus.carry_in = CARRY_OUT;

    aax_alu u_alu (
        .bus(alu_bus)
    );

    // Instructions are ignored while asleep, since the clock would be stopped.
    assign go = EXEC_IN && (pwr == aax_pkg::AAX_RUN);
    assign upd_z = (OP_IN == `AAX_OP_SUBL) || (OP_IN == `AAX_OP_SUBF) ||
                   (OP_IN == `AAX_OP_XORF) || (OP_IN == `AAX_OP_XORL);
    assign upd_cdc = (OP_IN == `AAX_OP_SUBL) || (OP_IN == `AAX_OP_SUBF);

    // Wake request comes from a pin, so it passes two flip-flops first.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
        end else begin
            wake_s1 <= WAKE_IN;
            wake_s2 <= wake_s1;
        end
    end

    // Power state decision.
    always_comb begin
        next_pwr = pwr;
        case (pwr)
            aax_pkg::AAX_RUN: begin
                if (go && OP_IN == `AAX_OP_SLEEP) begin
                    next_pwr = aax_pkg::AAX_ASLEEP;
                end
            end
            aax_pkg::AAX_ASLEEP: begin
                if (wake_s2) begin
                    next_pwr = aax_pkg::AAX_RUN;
                end
            end
            default: begin
                next_pwr = aax_pkg::AAX_RUN;
            end
        endcase
    end

    // Power state register; the oscillator runs only outside sleep.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            pwr <= aax_pkg::AAX_RUN;
        end else begin
            pwr <= next_pwr;
        end
    end
    assign OSC_RUN_OUT = (pwr == aax_pkg::AAX_RUN);
    assign SLEEPING_OUT = (pwr == aax_pkg::AAX_ASLEEP);

    // Watchdog and prescaler are cleared on sleep; counting lies elsewhere.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            WATCHDOG_COUNTER_OUT <= `AAX_WATCHDOG_CLR;
            PRESCALER_OUT <= `AAX_PRE_CLR;
            TIMEOUT_FLAG_N_OUT <= `AAX_TIMEOUT_N_RST;
            POWERDOWN_FLAG_N_OUT <= `AAX_POWERDOWN_N_RST;
        end else if (go && OP_IN == `AAX_OP_SLEEP) begin
            WATCHDOG_COUNTER_OUT <= `AAX_WATCHDOG_CLR;
            PRESCALER_OUT <= `AAX_PRE_CLR;
            TIMEOUT_FLAG_N_OUT <= 1'b1;
            POWERDOWN_FLAG_N_OUT <= 1'b0;
        end
    end

    // Working register: literal forms always, file forms when destination is zero.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            ACC_OUT <= `AAX_ACC_RST;
        end else if (go && OP_IN != `AAX_OP_SLEEP && OP_IN != `AAX_OP_NONE && OP_IN <= `AAX_OP_XORL) begin
            if (!is_file_op || DEST_IN == `AAX_DEST_ACC) begin
                ACC_OUT <= alu_bus.result;
            end
        end
    end

    // File write-back port, registered so data is stable for one cycle.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            FILE_WE_OUT <= 1'b0;
            FILE_WADDR_OUT <= 7'h00;
            FILE_WDATA_OUT <= 8'h00;
        end else begin
            FILE_WE_OUT <= go && is_file_op && DEST_IN == `AAX_DEST_FILE;
            FILE_WADDR_OUT <= FILE_ADDR_IN;
            FILE_WDATA_OUT <= alu_bus.result;
        end
    end

    // Status flags; swap and sleep leave them alone.
    always_ff @(posedge SYS_CLK_IN) begin
        if (!NRST_IN) begin
            CARRY_OUT <= 1'b0;
            DIGIT_CARRY_FLAG_OUT <= 1'b0;
            ZERO_OUT <= 1'b0;
        end else if (go) begin
            if (upd_cdc || OP_IN == `AAX_OP_ROTR) begin
                CARRY_OUT <= alu_bus.carry_out;
            end
            if (upd_cdc) begin
                DIGIT_CARRY_FLAG_OUT <= alu_bus.digit_carry_out;
            end
            if (upd_z) begin
                ZERO_OUT <= alu_bus.zero_out;
            end
        end
    end

    // Checks.
    property p_sleep_flags;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        (go && OP_IN == `AAX_OP_SLEEP) |=>
            (!POWERDOWN_FLAG_N_OUT && TIMEOUT_FLAG_N_OUT && WATCHDOG_COUNTER_OUT == 8'h00 &&
            PRESCALER_OUT == 8'h00);
    endproperty
    a_sleep_flags: assert property (p_sleep_flags) else $error("sleep flags wrong");

    property p_sleep_osc;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        (go && OP_IN == `AAX_OP_SLEEP) |=> !OSC_RUN_OUT;
    endproperty
    a_sleep_osc: assert property (p_sleep_osc) else $error("oscillator not stopped");

    property p_rotr;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        (go && OP_IN == `AAX_OP_ROTR) |=> (CARRY_OUT == $past(FILE_DATA_IN[0]) && $stable(ZERO_OUT));
    endproperty
    a_rotr: assert property (p_rotr) else $error("rotate carry wrong");

    property p_dest_file;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        (go && is_file_op && DEST_IN) |=> (FILE_WE_OUT && $stable(ACC_OUT));
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("destination wrong");

    property p_subl;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        (go && OP_IN == `AAX_OP_SUBL) |=>
            (ACC_OUT == 8'($past(LITERAL_IN) - $past(ACC_OUT)) && CARRY_OUT == ($past(ACC_OUT) <= $past(LITERAL_IN)));
    endproperty
    a_subl: assert property (p_subl) else $error("literal subtract wrong");

    property p_subf;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        (go && OP_IN == `AAX_OP_SUBF) |=>
            (DIGIT_CARRY_FLAG_OUT == ($past(ACC_OUT[3:0]) <= $past(FILE_DATA_IN[3:0])));
    endproperty
    a_subf: assert property (p_subf) else $error("file subtract digit carry wrong");

    property p_xorf;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        (go && OP_IN == `AAX_OP_XORF) |=> ($stable(CARRY_OUT) && $stable(DIGIT_CARRY_FLAG_OUT) &&
            ZERO_OUT == (($past(ACC_OUT) ^ $past(FILE_DATA_IN)) == 8'h00));
    endproperty
    a_xorf: assert property (p_xorf) else $error("xor touched carry");

    property p_swap;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        (go && OP_IN == `AAX_OP_SWAP && DEST_IN) |=>
            (FILE_WDATA_OUT == {$past(FILE_DATA_IN[3:0]), $past(FILE_DATA_IN[7:4])} && $stable(ZERO_OUT));
    endproperty
    a_swap: assert property (p_swap) else $error("swap wrong");

    property p_xorl;
        @(posedge SYS_CLK_IN) disable iff (!NRST_IN)
        (go && OP_IN == `AAX_OP_XORL) |=>
            (ACC_OUT == ($past(ACC_OUT) ^ $past(LITERAL_IN)) && ZERO_OUT == (ACC_OUT == 8'h00));
    endproperty
    a_xorl: assert property (p_xorl) else $error("literal xor wrong");
endmodule

// ### verilog/aax_regs.svh
`ifndef AAX_REGS_SVH
`define AAX_REGS_SVH

// Width of the datapath and of the file register address.
`define AAX_DATA_W 8
`define AAX_ADDR_W 7

// Operation codes presented by the decoder.
`define AAX_OP_NONE 4'h0
`define AAX_OP_SLEEP 4'h1
`define AAX_OP_ROTR 4'h2
`define AAX_OP_SUBL 4'h3
`define AAX_OP_SUBF 4'h4
`define AAX_OP_XORF 4'h5
`define AAX_OP_SWAP 4'h6
`define AAX_OP_XORL 4'h7

// Reset values of the working register, watchdog counter, prescaler and the timeout and power-down flags.
`define AAX_ACC_RST 8'h00
`define AAX_WATCHDOG_CLR 8'h00
`define AAX_PRE_CLR 8'h00
`define AAX_TIMEOUT_N_RST 1'b1
`define AAX_POWERDOWN_N_RST 1'b1

// Destination bit values.
`define AAX_DEST_ACC 1'b0
`define AAX_DEST_FILE 1'b1

`endif

// ### verilog/aax_pkg.sv
package aax_pkg;
    // Operation selector, matching the header codes.
    typedef enum logic [3:0] {
        AAX_NONE = 4'h0,
        AAX_SLEEP = 4'h1,
        AAX_ROTR = 4'h2,
        AAX_SUBL = 4'h3,
        AAX_SUBF = 4'h4,
        AAX_XORF = 4'h5,
        AAX_SWAP = 4'h6,
        AAX_XORL = 4'h7
    } aax_op_e;

    // Power state, Gray along run to sleep.
    typedef enum logic [1:0] {
        AAX_RUN = 2'b00,
        AAX_ASLEEP = 2'b01
    } aax_pwr_e;
endpackage

// ### verilog/aax_alu_if.sv
`timescale 1ns/1ps
// Carries operands and results between the top and the arithmetic unit.
interface aax_alu_if;
    logic [3:0] op; // Operation code.
    logic [7:0] acc; // Working register value.
    logic [7:0] opnd; // File value or literal.
    logic carry_in; // Current carry.
    logic [7:0] result; // Result byte.
    logic carry_out; // New carry.
    logic digit_carry_out; // New digit carry.
    logic zero_out; // Result is zero.
    modport top (output op, output acc, output opnd, output carry_in,
                 input result, input carry_out, input digit_carry_out, input zero_out);
    modport alu (input op, input acc, input opnd, input carry_in,
                 output result, output carry_out, output digit_carry_out, output zero_out);
endinterface

// ### verilog/aax_alu.sv
`timescale 1ns/1ps
`include "aax_regs.svh"
// Pure combinational arithmetic for the supported operations.
module aax_alu (
    aax_alu_if.alu bus
);
    // Zero test is used by every path that updates the zero flag.
    function automatic logic is_zero(input logic [7:0] v);
        is_zero = (v == 8'h00);
    endfunction

    logic [8:0] diff; // Operand minus accumulator with borrow bit.
    logic [4:0] ldiff; // Low nibble difference.

    // Subtraction: a clear borrow means accumulator <= operand.
    always_comb begin
        diff = {1'b0, bus.opnd} - {1'b0, bus.acc};
        ldiff = {1'b0, bus.opnd[3:0]} - {1'b0, bus.acc[3:0]};
    end

    // Result and flag selection.
    always_comb begin
        bus.result = bus.opnd;
        bus.carry_out = bus.carry_in;
        bus.digit_carry_out = 1'b0;
        case (bus.op)
            `AAX_OP_ROTR: begin
                bus.result = {bus.carry_in, bus.opnd[7:1]};
                bus.carry_out = bus.opnd[0];
            end
            `AAX_OP_SUBL, `AAX_OP_SUBF: begin
                bus.result = diff[7:0];
                bus.carry_out = ~diff[8];
                bus.digit_carry_out = ~ldiff[4];
            end
            `AAX_OP_XORF, `AAX_OP_XORL: begin
                bus.result = bus.acc ^ bus.opnd;
            end
            `AAX_OP_SWAP: begin
                bus.result = {bus.opnd[3:0], bus.opnd[7:4]};
            end
            default: begin
                bus.result = bus.opnd;
            end
        endcase
        bus.zero_out = is_zero(bus.result);
    end
endmodule

// ### sim/aax_tb.sv
`timescale 1ns/1ps
// Self-checking bench: the driver notes each expected result, a monitor compares.
module tb;
    logic SYS_CLK_IN = 1'b0; // 20 MHz system clock.
    logic NRST_IN = 1'b0; // Synchronous reset, active low.
    logic EXEC_IN = 1'b0;
    logic [3:0] OP_IN = 4'h0;
    logic DEST_IN = 1'b0;
    logic [6:0] FILE_ADDR_IN = 7'h00;
    logic [7:0] FILE_DATA_IN = 8'h00;
    logic [7:0] LITERAL_IN = 8'h00;
    logic WAKE_IN = 1'b0;
    logic [7:0] ACC_OUT, WATCHDOG_COUNTER_OUT, PRESCALER_OUT, FILE_WDATA_OUT;
    logic [6:0] FILE_WADDR_OUT;
    logic CARRY_OUT, DIGIT_CARRY_FLAG_OUT, ZERO_OUT, TIMEOUT_FLAG_N_OUT, POWERDOWN_FLAG_N_OUT;
    logic FILE_WE_OUT, OSC_RUN_OUT, SLEEPING_OUT;
    int n_fail = 0;
    int cmp_count = 0;
    logic [31:0] lfsr = 32'hc67b; // Random source with a fixed start.
    logic [31:0] notes[$]; // Expected results, oldest first.
    logic exec_d = 1'b0; // An operation was taken at the last rising edge.
    logic [7:0] m_acc = 8'h00; // Bench model of the working register.
    logic m_c = 1'b0, m_digit = 1'b0, m_z = 1'b0; // Bench model of the flags.

    // Free-running clock, 50 ns period.
    always #25 SYS_CLK_IN = ~SYS_CLK_IN;

    aax_core dut (.SYS_CLK_IN, .NRST_IN, .EXEC_IN, .OP_IN, .DEST_IN, .FILE_ADDR_IN, .FILE_DATA_IN,
        .LITERAL_IN, .WAKE_IN, .ACC_OUT, .CARRY_OUT, .DIGIT_CARRY_FLAG_OUT, .ZERO_OUT,
        .TIMEOUT_FLAG_N_OUT, .POWERDOWN_FLAG_N_OUT, .WATCHDOG_COUNTER_OUT, .PRESCALER_OUT,
        .FILE_WE_OUT, .FILE_WADDR_OUT, .FILE_WDATA_OUT, .OSC_RUN_OUT, .SLEEPING_OUT);

    // Galois shift register step used for all random stimulus.
    function automatic logic [31:0] next_rand(input logic [31:0] x);
        return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h00000000);
    endfunction

    // Compares one observed value against its expectation and counts both.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Drives one operation at the falling edge and notes what it must produce.
    task automatic issue(input logic [3:0] op, input logic dest, input logic [7:0] f,
                         input logic [7:0] k, input logic [6:0] a);
        logic [7:0] r;
        logic we;
        r = m_acc;
        we = 1'b0;
        @(negedge SYS_CLK_IN);
        EXEC_IN = 1'b1;
        OP_IN = op;
        DEST_IN = dest;
        FILE_DATA_IN = f;
        LITERAL_IN = k;
        FILE_ADDR_IN = a;
        case (op)
            4'h2: begin
                r = {m_c, f[7:1]};
                m_c = f[0];
            end
            4'h3: begin
                r = k - m_acc;
                m_c = m_acc <= k;
                m_digit = m_acc[3:0] <= k[3:0];
            end
            4'h4: begin
                r = f - m_acc;
                m_c = m_acc <= f;
                m_digit = m_acc[3:0] <= f[3:0];
            end
            4'h5: r = m_acc ^ f;
            4'h6: r = {f[3:0], f[7:4]};
            4'h7: r = m_acc ^ k;
            default: ;
        endcase
        // Only the subtracts and the exclusive-ORs touch the zero flag.
        if (op inside {4'h3, 4'h4, 4'h5, 4'h7}) m_z = (r == 8'h00);
        if (op inside {4'h2, 4'h4, 4'h5, 4'h6}) begin
            if (dest) we = 1'b1;
            else m_acc = r;
        end else if (op inside {4'h3, 4'h7}) begin
            m_acc = r;
        end
        notes.push_back({5'h00, m_acc, m_c, m_digit, m_z, we, we ? a : 7'h00, we ? r : 8'h00});
    endtask

    // Releases the execute strobe after a burst of operations.
    task automatic stop;
        @(negedge SYS_CLK_IN);
        EXEC_IN = 1'b0;
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Remembers whether the rising edge took an operation; sleep refuses it.
    always @(posedge SYS_CLK_IN) begin
        exec_d <= EXEC_IN && !SLEEPING_OUT && NRST_IN;
    end

    // Results are registered at the taking edge; compare at the next falling edge against the oldest note.
    always @(negedge SYS_CLK_IN) begin
        if (exec_d && notes.size() > 0) begin
            check({5'h00, ACC_OUT, CARRY_OUT, DIGIT_CARRY_FLAG_OUT, ZERO_OUT, FILE_WE_OUT,
                FILE_WE_OUT ? FILE_WADDR_OUT : 7'h00, FILE_WE_OUT ? FILE_WDATA_OUT : 8'h00},
                notes.pop_front());
        end
    end

    // Main sequence of tests.
    initial begin
        repeat (10) @(negedge SYS_CLK_IN);
        NRST_IN = 1'b1;
        check({ACC_OUT, CARRY_OUT, DIGIT_CARRY_FLAG_OUT, ZERO_OUT, FILE_WE_OUT, TIMEOUT_FLAG_N_OUT,
            POWERDOWN_FLAG_N_OUT, OSC_RUN_OUT, SLEEPING_OUT, 16'h0000}, 32'h000e0000);
        $display("test reset done");
        // Borrow, equal and low-nibble boundaries, then rotates and swaps back to back.
        issue(4'h7, 1'b0, 8'h00, 8'h03, 7'h00);
        issue(4'h3, 1'b0, 8'h00, 8'h05, 7'h00);
        issue(4'h3, 1'b0, 8'h00, 8'h01, 7'h00);
        issue(4'h3, 1'b0, 8'h00, 8'hff, 7'h00);
        issue(4'h4, 1'b1, 8'h10, 8'h00, 7'h7f);
        issue(4'h7, 1'b0, 8'h00, 8'h01, 7'h00);
        issue(4'h4, 1'b0, 8'h10, 8'h00, 7'h01);
        issue(4'h2, 1'b1, 8'h01, 8'h00, 7'h05);
        issue(4'h2, 1'b0, 8'h02, 8'h00, 7'h06);
        issue(4'h6, 1'b1, 8'ha5, 8'h00, 7'h07);
        issue(4'h6, 1'b0, 8'h3c, 8'h00, 7'h08);
        issue(4'h5, 1'b1, 8'hc3, 8'h00, 7'h09);
        issue(4'h5, 1'b0, 8'hc3, 8'h00, 7'h0a);
        issue(4'h0, 1'b1, 8'h55, 8'h55, 7'h0b);
        issue(4'hf, 1'b1, 8'h55, 8'h55, 7'h0c);
        $display("test directed done");
        // Random codes, including the unused ones; sleep is kept for its own test.
        for (int i = 0; i < 300; i++) begin
            lfsr = next_rand(lfsr);
            issue((lfsr[3:0] == 4'h1) ? 4'h0 : lfsr[3:0], lfsr[4], lfsr[12:5], lfsr[20:13], lfsr[27:21]);
        end
        stop();
        $display("test random done");
        issue(4'h1, 1'b0, 8'h00, 8'h00, 7'h00);
        stop();
        @(negedge SYS_CLK_IN);
        check({TIMEOUT_FLAG_N_OUT, POWERDOWN_FLAG_N_OUT, WATCHDOG_COUNTER_OUT, PRESCALER_OUT}, 32'h00020000);
        check({OSC_RUN_OUT, SLEEPING_OUT}, 32'h00000001);
        // An operation offered while asleep must leave the working register alone.
        EXEC_IN = 1'b1;
        OP_IN = 4'h7;
        LITERAL_IN = 8'hff;
        repeat (3) @(negedge SYS_CLK_IN);
        EXEC_IN = 1'b0;
        check({ACC_OUT, OSC_RUN_OUT}, {m_acc, 1'b0});
        WAKE_IN = 1'b1;
        for (int i = 0; i < 20 && OSC_RUN_OUT !== 1'b1; i++) @(negedge SYS_CLK_IN);
        WAKE_IN = 1'b0;
        check({OSC_RUN_OUT, SLEEPING_OUT}, 32'h00000002);
        issue(4'h7, 1'b0, 8'h00, 8'h5a, 7'h00);
        stop();
        repeat (3) @(negedge SYS_CLK_IN);
        check(notes.size(), 32'h00000000);
        $display("test sleep done");
        complete_run();
    end

    // Cuts a hang short; the whole run needs well under a thousand cycles.
    initial begin
        #(3000 * 50);
        n_fail++;
        $display("watchdog expired");
        complete_run();
    end
endmodule
